// >>> logic/hbd_top.sv
`timescale 1ns/100ps

// Notes on behaviour
// - Address decode is enabled while the qualifier is low or burst path select is low.
// - Address lines 4 to 15 decide whether a cycle hits the window.
// - Address lines 1 to 3 select the register inside the window.
// - Byte lane selects set access width and byte registers.
// - Burst path select low forces full 32-bit words.
// - Data bus is 32 bits, bidirectional; 16-bit hosts use low half.
// - Held reset resets MAC and PHY and restores register defaults.
// - After hardware reset the configuration is fetched from the EEPROM.
// - Reset counts only after 100 ns high; host holds it that long.
// - Address and qualifier are captured as the address strobe rises.
// - Internal decode uses latched copies; local-device decode uses live pins.
// - Cycle control low frames synchronous burst transfers.
// - Sync direction input high means write, low means read.
// - Bus type select low gives VL slave, high gives burst slave.
// - Bus type select does not affect asynchronous strobed accesses.
// - EEPROM supplies default I/O base and interrupt line choice.
// - Local-device output is a combinational base match on live inputs.
// - Burst path select low grants access regardless of address and qualifier.
module hbd_top (
   input wire logic clk_sys, // System clock, 50 MHz.
   input wire logic rst_b, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable, freezes state while low.
   input wire logic local_bus_clk, // Host local bus clock.
   input wire logic hw_reset_in, // Hardware reset pin, active high.
   input wire logic [hbd_pkg::ADDR_MSB:hbd_pkg::ADDR_LSB] host_addr, // Address lines.
   input wire logic addr_qualifier_n, // Address qualifier, active low.
   input wire logic addr_strobe_n, // Address strobe, active low.
   input wire logic [hbd_pkg::LANES-1:0] byte_lane_sel_n, // Byte lanes, active low.
   input wire logic burst_path_sel_n, // Burst data path select, active low.
   input wire logic burst_cycle_ctl_n, // Burst cycle control, active low.
   input wire logic cycle_direction, // Sync direction, high is write.
   input wire logic sync_bus_type_sel_n, // Low selects VL style cycles.
   input wire logic async_read_strobe_n, // Async read strobe, active low.
   input wire logic async_write_strobe_n, // Async write strobe, active low.
   input wire logic [hbd_pkg::DATA_W-1:0] host_data_bus_in, // Data bus input.
   output logic [hbd_pkg::DATA_W-1:0] host_data_bus_out, // Data bus output.
   output logic [hbd_pkg::DATA_W-1:0] host_data_bus_oe, // Data bus enable per bit.
   output logic local_device_hit_n, // Local device decode, active low.
   output hbd_pkg::hbd_req_t core_req, // Register access toward the core.
   output logic core_req_valid, // One-cycle pulse, core_req valid.
   input wire logic [hbd_pkg::DATA_W-1:0] core_rdata, // Read data, sampled on the edge that raises core_req_valid.
   output logic mac_phy_reset, // Internal MAC and PHY reset, active high.
   output logic cfg_load_req, // One-cycle pulse starting the EEPROM load.
   input wire logic cfg_load_done, // One-cycle pulse, cfg_in valid.
   input wire hbd_pkg::hbd_cfg_t cfg_in, // Configuration read from EEPROM.
   output hbd_pkg::hbd_cfg_t cfg_out // Configuration in force.
);

   localparam int AW = hbd_pkg::ADDR_MSB - hbd_pkg::ADDR_LSB + 1;
   localparam int SW = AW + 1 + 1 + hbd_pkg::LANES + 1 + 1 + 1 + hbd_pkg::DATA_W;

   // System domain.
   logic [SW-1:0] pin_s1_reg;
   logic [SW-1:0] pin_s2_reg;
   logic [2:0] rst_pin_reg;
   logic [hbd_pkg::FILT_W-1:0] filt_cnt_reg;
   hbd_pkg::hbd_rst_state_t rst_state_reg;
   hbd_pkg::hbd_rst_state_t rst_state_next;
   hbd_pkg::hbd_cfg_t cfg_reg;
   logic rd_prev_reg;
   logic wr_prev_reg;
   logic [hbd_pkg::DATA_W-1:0] s_rdata_reg;
   logic s_drive_reg;
   logic [hbd_pkg::LANES-1:0] s_lanes_reg;
   hbd_pkg::hbd_req_t req_reg;
   logic req_valid_reg;
   logic load_req_reg;
   logic [2:0] ltog_sync_reg;
   logic ltog_seen_reg;
   logic s_ack_tog_reg;
   logic l_tog_reg;

   wire [AW-1:0] s_addr = pin_s2_reg[SW-1 -: AW];
   wire s_qual_n = pin_s2_reg[SW-1-AW];
   wire s_strobe_n = pin_s2_reg[SW-2-AW];
   wire [hbd_pkg::LANES-1:0] s_lane_n = pin_s2_reg[SW-3-AW -: hbd_pkg::LANES];
   wire s_path_n = pin_s2_reg[SW-3-AW-hbd_pkg::LANES];
   wire s_rd_n = pin_s2_reg[SW-4-AW-hbd_pkg::LANES];
   wire s_wr_n = pin_s2_reg[SW-5-AW-hbd_pkg::LANES];
   wire [hbd_pkg::DATA_W-1:0] s_data = pin_s2_reg[hbd_pkg::DATA_W-1:0];
   wire [AW:0] s_lat;
   wire in_reset = (rst_state_reg == hbd_pkg::RS_RESET);

   // Pins pass two flip-flops before the system domain reads them.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1_reg <= '1;
         pin_s2_reg <= '1;
         rst_pin_reg <= '0;
      end else if (ce) begin
         pin_s1_reg <= {host_addr, addr_qualifier_n, addr_strobe_n, byte_lane_sel_n,
                        burst_path_sel_n, async_read_strobe_n, async_write_strobe_n,
                        host_data_bus_in};
         pin_s2_reg <= pin_s1_reg;
         rst_pin_reg <= {rst_pin_reg[1:0], hw_reset_in};
      end
   end

   // Address and qualifier latch for strobed accesses.
   hbd_addr_latch #(.W(AW + 1)) u_lat_sys (
      .clk(clk_sys),
      .rst_b(rst_b),
      .ce(ce),
      .strobe_n(s_strobe_n),
      .d({s_addr, s_qual_n}),
      .q(s_lat)
   );

   // Glitch filter counts consecutive high samples of the reset pin.
   wire rst_pin_hi = rst_pin_reg[1];
   wire filt_full = (filt_cnt_reg == hbd_pkg::FILT_W'(hbd_pkg::RESET_FILT_CYC));
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         filt_cnt_reg <= '0;
      end else if (ce) begin
         if (!rst_pin_hi) begin
            filt_cnt_reg <= '0;
         end else if (!filt_full) begin
            filt_cnt_reg <= filt_cnt_reg + hbd_pkg::FILT_W'(1);
         end
      end
   end

   // Reset sequence: held reset, then the EEPROM configuration load.
   always_comb begin
      rst_state_next = rst_state_reg;
      unique case (rst_state_reg)
         hbd_pkg::RS_RUN: begin
            if (filt_full) rst_state_next = hbd_pkg::RS_RESET;
         end
         hbd_pkg::RS_RESET: begin
            if (!rst_pin_hi) rst_state_next = hbd_pkg::RS_LOAD;
         end
         hbd_pkg::RS_LOAD: begin
            if (filt_full) begin
               rst_state_next = hbd_pkg::RS_RESET;
            end else if (cfg_load_done) begin
               rst_state_next = hbd_pkg::RS_RUN;
            end
         end
      endcase
   end

   // State, load pulse and configuration registers.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rst_state_reg <= hbd_pkg::RS_RUN;
         load_req_reg <= 1'b0;
         cfg_reg <= '{io_base: hbd_pkg::IO_BASE_RST, int_sel: hbd_pkg::INT_SEL_RST};
      end else if (ce) begin
         rst_state_reg <= rst_state_next;
         load_req_reg <= in_reset && (rst_state_next == hbd_pkg::RS_LOAD);
         if (in_reset) begin
            cfg_reg <= '{io_base: hbd_pkg::IO_BASE_RST, int_sel: hbd_pkg::INT_SEL_RST};
         end else if (rst_state_reg == hbd_pkg::RS_LOAD && cfg_load_done) begin
            cfg_reg <= cfg_in;
         end
      end
   end

   // Strobed access decode; the bus type select plays no part here.
   wire rd_fall = rd_prev_reg && !s_rd_n;
   wire wr_rise = !wr_prev_reg && s_wr_n;
   wire s_hit = hbd_pkg::hbd_hit(s_lat[AW:1], s_lat[0], cfg_reg.io_base, s_path_n);
   wire a_take = !in_reset && (rd_fall || wr_rise) && s_hit;
   wire [hbd_pkg::LANES-1:0] a_lanes = hbd_pkg::hbd_lanes(s_lane_n, s_path_n);
   wire ltog_pend = (ltog_sync_reg[2] != ltog_seen_reg);
   wire l_take_s = !in_reset && ltog_pend && !a_take;
   hbd_pkg::hbd_req_t a_req;
   hbd_pkg::hbd_req_t l_req_reg;
   assign a_req = '{write: wr_rise, burst: !s_path_n,
                    reg_sel: s_lat[hbd_pkg::SEL_MSB:hbd_pkg::SEL_LSB],
                    lanes: a_lanes, wdata: s_data};

   // Request issue toward the core; strobed accesses win over link ones.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rd_prev_reg <= 1'b1;
         wr_prev_reg <= 1'b1;
         req_reg <= '0;
         req_valid_reg <= 1'b0;
         ltog_sync_reg <= '0;
         ltog_seen_reg <= 1'b0;
         s_ack_tog_reg <= 1'b0;
      end else if (ce) begin
         rd_prev_reg <= s_rd_n;
         wr_prev_reg <= s_wr_n;
         ltog_sync_reg <= {ltog_sync_reg[1:0], l_tog_reg};
         req_valid_reg <= a_take || l_take_s;
         req_reg <= a_take ? a_req : l_req_reg;
         if (in_reset) begin
            ltog_seen_reg <= ltog_sync_reg[2];
            s_ack_tog_reg <= ltog_sync_reg[2] ^ ltog_seen_reg ^ s_ack_tog_reg;
         end else if (l_take_s) begin
            ltog_seen_reg <= ltog_sync_reg[2];
            s_ack_tog_reg <= !s_ack_tog_reg;
         end
      end
   end

   // Read data capture and async drive window.
   wire a_read = a_take && rd_fall;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_rdata_reg <= '0;
         s_drive_reg <= 1'b0;
         s_lanes_reg <= '0;
      end else if (ce) begin
         if (a_read || (l_take_s && !l_req_reg.write)) begin
            s_rdata_reg <= core_rdata;
         end
         if (a_read) begin
            s_drive_reg <= 1'b1;
            s_lanes_reg <= a_lanes;
         end else if (s_rd_n || in_reset) begin
            s_drive_reg <= 1'b0;
         end
      end
   end

   // Link domain.
   logic [1:0] l_ce_reg;
   logic [2:0] ack_sync_reg;
   logic ack_seen_reg;
   logic l_busy_reg;
   logic l_drive_reg;
   logic [hbd_pkg::LANES-1:0] l_lanes_reg;
   logic [hbd_pkg::DATA_W-1:0] l_rdata_reg;
   wire [AW:0] l_lat;

   // Link side latch takes the pins directly: they are timed to this clock.
   hbd_addr_latch #(.W(AW + 1)) u_lat_link (
      .clk(local_bus_clk),
      .rst_b(rst_b),
      .ce(l_ce_reg[1]),
      .strobe_n(addr_strobe_n),
      .d({host_addr, addr_qualifier_n}),
      .q(l_lat)
   );

   // VL cycles start on a strobe sample; burst cycles on each framed edge.
   wire vl_mode = !sync_bus_type_sel_n;
   wire l_start = vl_mode ? !addr_strobe_n : !burst_cycle_ctl_n;
   wire l_hit = hbd_pkg::hbd_hit(l_lat[AW:1], l_lat[0], cfg_reg.io_base,
                                 burst_path_sel_n);
   wire l_take = l_ce_reg[1] && l_start && l_hit && !l_busy_reg;
   wire l_ack = (ack_sync_reg[2] != ack_seen_reg);
   wire [hbd_pkg::LANES-1:0] l_lanes = hbd_pkg::hbd_lanes(byte_lane_sel_n,
                                                         burst_path_sel_n);

   // Request hold register and toggle handshake toward the system domain.
   always_ff @(posedge local_bus_clk or negedge rst_b) begin
      if (!rst_b) begin
         l_ce_reg <= '0;
         l_tog_reg <= 1'b0;
         l_req_reg <= '0;
         l_busy_reg <= 1'b0;
         ack_sync_reg <= '0;
         ack_seen_reg <= 1'b0;
      end else begin
         l_ce_reg <= {l_ce_reg[0], ce};
         if (l_ce_reg[1]) begin
            ack_sync_reg <= {ack_sync_reg[1:0], s_ack_tog_reg};
            if (l_take) begin
               l_req_reg <= '{write: cycle_direction, burst: !burst_path_sel_n,
                              reg_sel: l_lat[hbd_pkg::SEL_MSB:hbd_pkg::SEL_LSB],
                              lanes: l_lanes, wdata: host_data_bus_in};
               l_tog_reg <= !l_tog_reg;
               l_busy_reg <= 1'b1;
            end else if (l_ack) begin
               ack_seen_reg <= ack_sync_reg[2];
               l_busy_reg <= 1'b0;
            end
         end
      end
   end

   // Read data returned over the handshake is driven until the next cycle.
   always_ff @(posedge local_bus_clk or negedge rst_b) begin
      if (!rst_b) begin
         l_drive_reg <= 1'b0;
         l_rdata_reg <= '0;
         l_lanes_reg <= '0;
      end else if (l_ce_reg[1]) begin
         if (l_ack && !l_req_reg.write) begin
            l_rdata_reg <= s_rdata_reg;
            l_lanes_reg <= l_req_reg.lanes;
            l_drive_reg <= 1'b1;
         end else if (l_take || cycle_direction) begin
            l_drive_reg <= 1'b0;
         end
      end
   end

   // Outputs.
   // Each lane enable covers its eight data bits.
   genvar g;
   generate
      for (g = 0; g < hbd_pkg::LANES; g++) begin : g_lane
         assign host_data_bus_oe[g*hbd_pkg::LANE_W +: hbd_pkg::LANE_W] =
            {hbd_pkg::LANE_W{(s_drive_reg && s_lanes_reg[g]) ||
                             (l_drive_reg && l_lanes_reg[g])}};
      end
   endgenerate

   // Data, core request and reset outputs.
   assign host_data_bus_out = s_drive_reg ? s_rdata_reg : l_rdata_reg;
   assign local_device_hit_n = !(!addr_qualifier_n &&
      (host_addr[hbd_pkg::BASE_MSB:hbd_pkg::BASE_LSB] == cfg_reg.io_base));
   assign core_req = req_reg;
   assign core_req_valid = req_valid_reg;
   assign mac_phy_reset = in_reset;
   assign cfg_load_req = load_req_reg;
   assign cfg_out = cfg_reg;

endmodule

// >>> logic/hbd_pkg.sv
package hbd_pkg;

   // Bus geometry.
   localparam int ADDR_MSB = 15;
   localparam int ADDR_LSB = 1;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam int LANE_W = 8;
   localparam int BASE_W = 12;
   localparam int SEL_W = 3;

   // Address field positions on host_addr.
   localparam int SEL_LSB = 1;
   localparam int SEL_MSB = 3;
   localparam int BASE_LSB = 4;
   localparam int BASE_MSB = 15;

   // Reset glitch filter: least pulse width and its cycle count at clk_sys.
   localparam int T_RESET_MIN_NS = 100;
   localparam int CLK_SYS_MHZ = 50;
   localparam int RESET_FILT_CYC = (T_RESET_MIN_NS * CLK_SYS_MHZ + 999) / 1000;
   localparam int FILT_W = $clog2(RESET_FILT_CYC + 1);

   // Configuration defaults used until the EEPROM load completes.
   localparam logic [BASE_W-1:0] IO_BASE_RST = 12'h030;
   localparam logic [1:0] INT_SEL_RST = 2'h0;
   localparam logic [LANES-1:0] LANES_ALL = 4'hf;

   typedef struct packed {
      logic write;
      logic burst;
      logic [SEL_W-1:0] reg_sel;
      logic [LANES-1:0] lanes;
      logic [DATA_W-1:0] wdata;
   } hbd_req_t;

   typedef struct packed {
      logic [BASE_W-1:0] io_base;
      logic [1:0] int_sel;
   } hbd_cfg_t;

   typedef enum logic [1:0] {
      RS_RUN,
      RS_RESET,
      RS_LOAD
   } hbd_rst_state_t;

   // Window hit: qualifier low and base match, or the burst data path select.
   function automatic logic hbd_hit(input logic [ADDR_MSB:ADDR_LSB] addr,
                                    input logic qual_n,
                                    input logic [BASE_W-1:0] base,
                                    input logic path_n);
      hbd_hit = !path_n || (!qual_n && (addr[BASE_MSB:BASE_LSB] == base));
   endfunction

   // Active lanes: all four in burst, otherwise from the active-low selects.
   function automatic logic [LANES-1:0] hbd_lanes(input logic [LANES-1:0] sel_n,
                                                  input logic path_n);
      hbd_lanes = path_n ? ~sel_n : LANES_ALL;
   endfunction

endpackage

// >>> logic/hbd_addr_latch.sv
`timescale 1ns/100ps

// Address and qualifier latch: follows the input while the strobe is low
// and holds the last value seen low once the strobe rises.
module hbd_addr_latch #(
   parameter int W = 16
) (
   input wire logic clk, // Clock of the owning domain.
   input wire logic rst_b, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable.
   input wire logic strobe_n, // Address strobe, active low.
   input wire logic [W-1:0] d, // Live address and qualifier.
   output logic [W-1:0] q // Latched view.
);

   logic [W-1:0] hold_reg;

   // Capture while the strobe is low; the rising edge freezes the value.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hold_reg <= '0;
      end else if (ce && !strobe_n) begin
         hold_reg <= d;
      end
   end

   // Transparent while low, held while high.
   assign q = strobe_n ? hold_reg : d;

endmodule

// >>> verif/hbd_checker.sv
`timescale 1ns/100ps

// Port-level checks of the host front end.
module hbd_checker (
   input wire logic clk_sys, // System clock.
   input wire logic rst_b, // Reset, active low.
   input wire logic hw_reset_in, // Reset pin.
   input wire logic [hbd_pkg::ADDR_MSB:hbd_pkg::ADDR_LSB] host_addr, // Address.
   input wire logic addr_qualifier_n, // Qualifier.
   input wire logic local_device_hit_n, // Local decode.
   input wire logic [hbd_pkg::DATA_W-1:0] host_data_bus_oe, // Bus enables.
   input wire hbd_pkg::hbd_req_t core_req, // Request.
   input wire logic core_req_valid, // Request strobe.
   input wire logic mac_phy_reset, // Internal reset.
   input wire logic cfg_load_req, // Load start.
   input wire logic cfg_load_done, // Load end.
   input wire hbd_pkg::hbd_cfg_t cfg_in, // Loaded value.
   input wire hbd_pkg::hbd_cfg_t cfg_out // Value in force.
);
   logic [3:0] hi_cnt_reg;
   logic [3:0] hi_cnt_next;

   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   // Counts consecutive high samples of the reset pin, saturating.
   assign hi_cnt_next = !hw_reset_in ? 4'h0 : (hi_cnt_reg == 4'hf ? 4'hf : hi_cnt_reg + 4'h1);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hi_cnt_reg <= 4'h0;
      end else begin
         hi_cnt_reg <= hi_cnt_next;
      end
   end

   // A reset that was held and has just been let go.
   sequence s_reset_end;
      mac_phy_reset ##1 !mac_phy_reset;
   endsequence

   AST_LDEV: assert property (
      local_device_hit_n == !(!addr_qualifier_n &&
      host_addr[hbd_pkg::BASE_MSB:hbd_pkg::BASE_LSB] == cfg_out.io_base))
      else $error("local decode wrong");
   AST_BURST_LANES: assert property (
      core_req_valid && core_req.burst |-> core_req.lanes == hbd_pkg::LANES_ALL)
      else $error("burst request not full word");
   AST_RST_CFG: assert property (
      mac_phy_reset [*2] |-> cfg_out == {hbd_pkg::IO_BASE_RST, hbd_pkg::INT_SEL_RST})
      else $error("config not default in reset");
   AST_FILT_MIN: assert property (
      $rose(mac_phy_reset) |-> hi_cnt_reg >= 4'h5)
      else $error("reset taken from short pulse");
   AST_FILT_MAX: assert property (
      hi_cnt_reg == 4'ha |-> mac_phy_reset)
      else $error("held reset not taken");
   AST_LOAD_REQ: assert property (
      s_reset_end |-> ##[0:3] cfg_load_req)
      else $error("no load after reset");
   AST_CFG_LOAD: assert property (
      cfg_load_done |=> cfg_out == $past(cfg_in))
      else $error("loaded config not in force");
   AST_OE_LANE: assert property (
      host_data_bus_oe == {{8{host_data_bus_oe[31]}}, {8{host_data_bus_oe[23]}},
      {8{host_data_bus_oe[15]}}, {8{host_data_bus_oe[7]}}})
      else $error("bus enable splits a lane");
endmodule

bind hbd_top hbd_checker u_chk (
   .clk_sys, .rst_b, .hw_reset_in, .host_addr, .addr_qualifier_n, .local_device_hit_n,
   .host_data_bus_oe, .core_req, .core_req_valid, .mac_phy_reset, .cfg_load_req,
   .cfg_load_done, .cfg_in, .cfg_out
);

// >>> verif/hbd_host_model.sv
`timescale 1ns/100ps

// Host model: strobed cycles and link cycles.
module hbd_host_model (
   input wire logic clk_sys, // Pacing clock.
   input wire logic [31:0] host_bus, // Resolved data bus.
   output logic local_bus_clk, // Link clock.
   output logic [15:1] host_addr, // Address.
   output logic addr_qualifier_n, // Qualifier.
   output logic addr_strobe_n, // Address strobe.
   output logic [3:0] byte_lane_sel_n, // Lanes.
   output logic burst_path_sel_n, // Burst path.
   output logic burst_cycle_ctl_n, // Burst cycle.
   output logic cycle_direction, // Direction.
   output logic sync_bus_type_sel_n, // Link flavour.
   output logic async_read_strobe_n, // Read strobe.
   output logic async_write_strobe_n, // Write strobe.
   output logic [31:0] host_drive // Host data.
);
   logic run = 1'b0;
   logic [31:0] rdat = 32'h0;

   // Link clock stands high between frames; slow in burst flavour.
   initial begin
      local_bus_clk = 1'b1;
      #7;
      forever begin
         #(sync_bus_type_sel_n ? 60 : 16) local_bus_clk = run ? ~local_bus_clk : 1'b1;
      end
   end

   // Idle bus at time zero.
   initial begin
      put(15'h0, 1'b1, 4'hf, 1'b1, 32'hffffffff);
      addr_strobe_n = 1'b0;
      burst_cycle_ctl_n = 1'b1;
      cycle_direction = 1'b0;
      sync_bus_type_sel_n = 1'b1;
      async_read_strobe_n = 1'b1;
      async_write_strobe_n = 1'b1;
   end

   // Presents fields, held stable until changed.
   task automatic put(input logic [15:1] a, input logic q, input logic [3:0] b,
      input logic p, input logic [31:0] d);
      host_addr = a;
      addr_qualifier_n = q;
      byte_lane_sel_n = b;
      burst_path_sel_n = p;
      host_drive = d;
   endtask

   // Released lines: address shows its inverse, data floats to its pull-ups.
   task automatic release_bus;
      host_addr = ~host_addr;
      byte_lane_sel_n = ~byte_lane_sel_n;
      addr_qualifier_n = 1'b1;
      burst_path_sel_n = 1'b1;
      host_drive = 32'hffffffff;
   endtask

   // Strobed cycle: strobe low five cycles, fields held six more.
   task automatic acyc(input logic w, input logic [15:1] a, input logic q,
      input logic [3:0] b, input logic p, input logic [31:0] d);
      @(negedge clk_sys);
      put(a, q, b, p, w ? d : 32'hffffffff);
      async_write_strobe_n = !w;
      async_read_strobe_n = w;
      repeat (5) @(negedge clk_sys);
      rdat = host_bus;
      async_write_strobe_n = 1'b1;
      async_read_strobe_n = 1'b1;
      repeat (6) @(negedge clk_sys);
      release_bus();
   endtask

   // Link write: lead-in edges, one start edge, then edges for the answer.
   task automatic lcyc(input logic vl, input logic [15:1] a, input logic [3:0] b,
      input logic [31:0] d);
      put(a, 1'b0, b, 1'b1, d);
      cycle_direction = 1'b1;
      sync_bus_type_sel_n = !vl;
      addr_strobe_n = vl;
      run = 1'b1;
      repeat (4) @(negedge local_bus_clk);
      addr_strobe_n = !vl;
      burst_cycle_ctl_n = vl;
      @(negedge local_bus_clk);
      addr_strobe_n = 1'b1;
      burst_cycle_ctl_n = 1'b1;
      repeat (8) @(negedge local_bus_clk);
      run = 1'b0;
      addr_strobe_n = 1'b0;
      sync_bus_type_sel_n = 1'b1;
      release_bus();
   endtask
endmodule

// >>> verif/host_bus_address_decode_tb.sv
`timescale 1ns/100ps

// Self-checking bench for the host front end.
module host_bus_address_decode_tb;
   localparam logic [11:0] BASE = hbd_pkg::IO_BASE_RST;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic hw_reset_in = 1'b0;
   logic cfg_load_done = 1'b0;
   hbd_pkg::hbd_cfg_t cfg_in = '0;
   logic [31:0] core_rdata = 32'h5a3c9617;
   logic local_bus_clk, addr_qualifier_n, addr_strobe_n, burst_path_sel_n;
   logic burst_cycle_ctl_n, cycle_direction, sync_bus_type_sel_n;
   logic async_read_strobe_n, async_write_strobe_n;
   logic local_device_hit_n, core_req_valid, mac_phy_reset, cfg_load_req;
   logic [15:1] host_addr;
   logic [3:0] byte_lane_sel_n;
   logic [31:0] host_data_bus_out, host_data_bus_oe, host_drive, host_bus;
   hbd_pkg::hbd_req_t core_req, last_req;
   hbd_pkg::hbd_cfg_t cfg_out;
   int n_mismatch = 0;
   int n_compared = 0;
   int n_req = 0;

   // Wire level: device lanes where enabled, host or pull-ups elsewhere.
   assign host_bus = (host_data_bus_out & host_data_bus_oe) | (host_drive & ~host_data_bus_oe);

   hbd_top u_dut (
      .clk_sys, .rst_b, .ce(1'b1), .local_bus_clk, .hw_reset_in, .host_addr,
      .addr_qualifier_n, .addr_strobe_n, .byte_lane_sel_n, .burst_path_sel_n,
      .burst_cycle_ctl_n, .cycle_direction, .sync_bus_type_sel_n,
      .async_read_strobe_n, .async_write_strobe_n, .host_data_bus_in(host_bus),
      .host_data_bus_out, .host_data_bus_oe, .local_device_hit_n, .core_req,
      .core_req_valid, .core_rdata, .mac_phy_reset, .cfg_load_req, .cfg_load_done,
      .cfg_in, .cfg_out
   );

   hbd_host_model u_host (
      .clk_sys, .host_bus, .local_bus_clk, .host_addr, .addr_qualifier_n,
      .addr_strobe_n, .byte_lane_sel_n, .burst_path_sel_n, .burst_cycle_ctl_n,
      .cycle_direction, .sync_bus_type_sel_n, .async_read_strobe_n,
      .async_write_strobe_n, .host_drive
   );

   // System clock.
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end

   // Records every request handed to the core.
   always @(posedge clk_sys) begin
      if (core_req_valid === 1'b1) begin
         n_req <= n_req + 1;
         last_req <= core_req;
      end
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Strobed write; n is the number of requests it should raise.
   task automatic aw(input logic [15:1] a, input logic q, input logic [3:0] b,
      input logic p, input logic [31:0] d, input int n);
      int n0;
      n0 = n_req;
      u_host.acyc(1'b1, a, q, b, p, d);
      check(64'(n_req - n0), 64'(n));
      if (n == 1) begin
         check(last_req, {1'b1, !p, a[3:1], p ? ~b : 4'hf, d});
      end
   endtask

   task automatic t_reset;
      check(cfg_out, {hbd_pkg::IO_BASE_RST, hbd_pkg::INT_SEL_RST});
      check(host_data_bus_oe, 32'h0);
      check(core_req_valid, 1'b0);
   endtask

   task automatic t_async;
      for (int t = 0; t < 2; t++) begin
         u_host.sync_bus_type_sel_n = t[0];
         aw({BASE, 3'(t + 2)}, 1'b0, 4'b1010, 1'b1, 32'hc0de0001 + t, 1);
      end
      aw({BASE, 3'h1}, 1'b1, 4'h0, 1'b1, 32'h11111111, 0);
      aw({BASE + 12'h1, 3'h1}, 1'b0, 4'h0, 1'b1, 32'h22222222, 0);
      aw({BASE + 12'h1, 3'h7}, 1'b1, 4'b1110, 1'b0, 32'h33333333, 1);
   endtask

   task automatic t_read;
      for (int i = 0; i < 2; i++) begin
         u_host.acyc(1'b0, {BASE, 3'h4}, 1'b0, i ? 4'h0 : 4'b1100, 1'b1, 32'h0);
         check(u_host.rdat, i ? core_rdata : {16'hffff, core_rdata[15:0]});
         check(last_req[40:32], {5'h04, i ? 4'hf : 4'b0011});
      end
   endtask

   task automatic t_latch;
      int n0;
      @(negedge clk_sys);
      u_host.put({BASE, 3'h6}, 1'b0, 4'hf, 1'b1, 32'hffffffff);
      repeat (4) @(negedge clk_sys);
      u_host.addr_strobe_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      u_host.put({~BASE, 3'h1}, 1'b1, 4'h0, 1'b1, 32'h44444444);
      #1;
      check(local_device_hit_n, 1'b1);
      n0 = n_req;
      u_host.acyc(1'b1, {~BASE, 3'h1}, 1'b1, 4'h0, 1'b1, 32'h44444444);
      check(64'(n_req - n0), 64'h1);
      check(last_req, {2'b10, 3'h6, 4'hf, 32'h44444444});
      u_host.addr_strobe_n = 1'b0;
   endtask

   task automatic t_link;
      for (int v = 0; v < 2; v++) begin
         int n0;
         n0 = n_req;
         u_host.lcyc(v[0], {BASE, 3'h5}, 4'b0101, 32'h600d0000 + v);
         check(64'(n_req - n0), 64'h1);
         check(last_req, {2'b10, 3'h5, 4'b1010, 32'h600d0000 + v});
      end
   endtask

   task automatic t_hwrst;
      logic seen = 1'b0;
      int k;
      @(negedge clk_sys);
      hw_reset_in = 1'b1;
      repeat (3) @(negedge clk_sys);
      hw_reset_in = 1'b0;
      repeat (12) begin
         @(negedge clk_sys);
         seen = seen | mac_phy_reset;
      end
      check(seen, 1'b0);
      for (int i = 0; i < 2; i++) begin
         hw_reset_in = 1'b1;
         repeat (12) @(negedge clk_sys);
         check(mac_phy_reset, 1'b1);
         check(cfg_out, {hbd_pkg::IO_BASE_RST, hbd_pkg::INT_SEL_RST});
         hw_reset_in = 1'b0;
         k = 0;
         while (cfg_load_req !== 1'b1 && k < 20) begin
            @(negedge clk_sys);
            k++;
         end
         if (k == 20) begin
            n_mismatch++;
            conclude();
         end
         cfg_in = {12'h0a5 + 12'(i), 2'(i + 1)};
         cfg_load_done = 1'b1;
         @(negedge clk_sys);
         cfg_load_done = 1'b0;
         @(negedge clk_sys);
         check(cfg_out, cfg_in);
      end
      u_host.put({12'h0a6, 3'h0}, 1'b0, 4'hf, 1'b1, 32'hffffffff);
      #1;
      check(local_device_hit_n, 1'b0);
      u_host.release_bus();
   endtask

   // Reset, then the scenarios, then the verdict.
   initial begin
      repeat (3) @(negedge clk_sys);
      rst_b = 1'b1;
      repeat (4) @(negedge clk_sys);
      t_reset();
      t_async();
      t_read();
      t_latch();
      t_link();
      t_hwrst();
      conclude();
   end
endmodule
